// file: rtl/ata_write_verify_sequencer.sv
`timescale 1ns/100ps
module ata_write_verify_sequencer
  import ata_wv_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic [3:0]  ADDR_I,
  input  wire logic [15:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [15:0] RDATA_O,
  output logic             IRQ_O,
  output logic             MEDIA_REQ_O,
  output logic      [1:0]  MEDIA_OP_O,
  output logic      [47:0] MEDIA_ADDR_O,
  output logic             MEDIA_CHS_O,
  input  wire logic        MEDIA_DONE_I,
  input  wire logic        MEDIA_FAIL_I,
  input  wire logic [7:0]  MEDIA_ERRCODE_I,
  input  wire logic [7:0]  MEDIA_WIDX_I,
  output logic      [15:0] MEDIA_WDATA_O
);

  typedef enum logic [2:0] {
    S_IDLE,
    S_XFER,
    S_CHECK,
    S_SEEK,
    S_MEDIA
  } seq_state_t;

  seq_state_t  state_q, state_d;
  logic [7:0]  cur_q [TF_NUM];
  logic [7:0]  cur_d [TF_NUM];
  logic [7:0]  prev_q [TF_NUM];
  logic [7:0]  prev_d [TF_NUM];
  logic [7:0]  dh_q, dh_d;
  logic        hob_q, hob_d;
  logic        bsy_q, bsy_d;
  logic        drq_q, drq_d;
  logic        err_q, err_d;
  logic [7:0]  ecode_q, ecode_d;
  logic [47:0] addr_q, addr_d;
  logic [16:0] remain_q, remain_d;
  logic        wrc_q, wrc_d;
  logic        ext_q, ext_d;
  logic        chs_q, chs_d;
  logic [7:0]  widx_q, widx_d;
  logic [35:0] head_trk_q, head_trk_d;
  logic        req_q, req_d;
  media_op_t   op_q, op_d;
  logic        evt_cmd, evt_err;
  logic [1:0]  istat_q, istat_d;
  logic [1:0]  imask_q, imask_d;
  logic        irq_q, irq_d;
  logic [15:0] rdata_q, rdata_d;
  logic [15:0] mwdata_q;
  logic [15:0] buf_q [SECTOR_WORDS];
  logic        buf_we;
  logic [2:0]  tf_idx;
  logic        tf_hit;
  logic [7:0]  cmd;
  logic        is_ext, is_wr, is_vf, lba_mode;
  logic [47:0] start_addr, next_addr;
  logic [16:0] start_cnt;
  logic [35:0] tgt_trk;
  logic        adv;

  // task-file register addressed by the port
  assign tf_idx = ADDR_I[2:0] - 3'h1;
  assign tf_hit = (ADDR_I >= OFS_FEATURES) && (ADDR_I <= OFS_CYL_HI);

  // command decode and starting address from the task file
  always_comb begin
    cmd      = WDATA_I[7:0];
    lba_mode = dh_q[DH_LBA];
    is_ext   = (cmd == CMD_WRITE_EXT) || (cmd == CMD_VERIFY_EXT);
    is_wr    = (cmd == CMD_WRITE) || (cmd == CMD_WRITE_NR) ||          // RQ1
               (cmd == CMD_WRITE_EXT) || (cmd == CMD_WRITE_VFY);       // RQ11 RQ16
    is_vf    = (cmd == CMD_VERIFY) || (cmd == CMD_VERIFY_EXT);         // RQ13 RQ15
    if (is_ext) begin
      start_addr = {prev_q[TF_CYL_HI], prev_q[TF_CYL_LO], prev_q[TF_SNUM],
                    cur_q[TF_CYL_HI], cur_q[TF_CYL_LO], cur_q[TF_SNUM]};  // RQ18
      start_cnt  = {(prev_q[TF_SCOUNT] == RST_BYTE) && (cur_q[TF_SCOUNT] == RST_BYTE),
                    prev_q[TF_SCOUNT], cur_q[TF_SCOUNT]};             // RQ11
    end else begin
      if (lba_mode) begin
        start_addr = {20'h0, dh_q[3:0], cur_q[TF_CYL_HI], cur_q[TF_CYL_LO], cur_q[TF_SNUM]};
      end else begin
        start_addr = {16'h0, cur_q[TF_CYL_HI], cur_q[TF_CYL_LO], 4'h0, dh_q[3:0], cur_q[TF_SNUM]};
      end
      start_cnt = {8'h0, cur_q[TF_SCOUNT] == RST_BYTE, cur_q[TF_SCOUNT]}; // RQ1
    end
  end

  // track of the current sector and the address that follows it
  always_comb begin
    tgt_trk   = chs_q ? {20'h0, addr_q[31:16]} : addr_q[47:TRACK_LSB];
    next_addr = addr_q + 48'h1;
    if (chs_q) begin
      next_addr = addr_q;
      if (addr_q[7:0] >= SECT_PER_TRK) begin
        next_addr[7:0] = RST_SNUM;
        if (addr_q[11:8] == LAST_HEAD) begin
          next_addr[11:8]  = 4'h0;
          next_addr[31:16] = addr_q[31:16] + 16'h1;
        end else begin
          next_addr[11:8] = addr_q[11:8] + 4'h1;
        end
      end else begin
        next_addr[7:0] = addr_q[7:0] + 8'h1;
      end
    end
  end

  // sequencer and task file next state
  always_comb begin
    state_d    = state_q;
    cur_d      = cur_q;
    prev_d     = prev_q;
    dh_d       = dh_q;
    hob_d      = hob_q;
    bsy_d      = bsy_q;
    drq_d      = drq_q;
    err_d      = err_q;
    ecode_d    = ecode_q;
    addr_d     = addr_q;
    remain_d   = remain_q;
    wrc_d      = wrc_q;
    ext_d      = ext_q;
    chs_d      = chs_q;
    widx_d     = widx_q;
    head_trk_d = head_trk_q;
    req_d      = req_q && !MEDIA_DONE_I;
    op_d       = op_q;
    evt_cmd    = 1'b0;
    evt_err    = 1'b0;
    buf_we     = 1'b0;
    adv        = 1'b0;
    if (WR_I && (ADDR_I == OFS_DEVCTL)) begin
      hob_d = WDATA_I[DEVCTL_HOB];
    end
    unique case (state_q)
      S_IDLE: begin
        if (WR_I && tf_hit) begin
          prev_d[tf_idx] = cur_q[tf_idx];                             // RQ18
          cur_d[tf_idx]  = WDATA_I[7:0];
        end
        if (WR_I && (ADDR_I == OFS_DRVHEAD)) begin
          dh_d = WDATA_I[7:0];
        end
        if (WR_I && (ADDR_I == OFS_CMD_STAT)) begin
          err_d   = 1'b0;
          ecode_d = RST_BYTE;
          if (!(is_wr || is_vf) || (is_ext && !lba_mode)) begin       // RQ12
            err_d             = 1'b1;
            ecode_d[ERR_ABRT] = 1'b1;
            evt_cmd           = 1'b1;
            evt_err           = 1'b1;
          end else begin
            addr_d   = start_addr;
            remain_d = start_cnt;
            wrc_d    = is_wr;
            ext_d    = is_ext;
            chs_d    = !lba_mode;
            widx_d   = 8'h0;
            if (is_wr) begin
              drq_d   = 1'b1;                                         // RQ2
              state_d = S_XFER;
            end else begin
              bsy_d   = 1'b1;                                         // RQ13
              state_d = S_CHECK;
            end
          end
        end
      end
      S_XFER: begin
        if (WR_I && (ADDR_I == OFS_DATA)) begin
          buf_we = 1'b1;                                              // RQ2
          widx_d = widx_q + 8'h1;
          if (widx_q == LAST_WORD) begin
            drq_d   = 1'b0;                                           // RQ3 RQ5
            bsy_d   = 1'b1;
            state_d = S_CHECK;
          end
        end
      end
      S_CHECK: begin
        req_d = 1'b1;
        if (tgt_trk != head_trk_q) begin
          op_d    = MOP_SEEK;                                         // RQ6
          state_d = S_SEEK;
        end else begin
          op_d    = wrc_q ? MOP_WRITE : MOP_VERIFY;                   // RQ3 RQ16
          state_d = S_MEDIA;
        end
      end
      S_SEEK: begin
        if (MEDIA_DONE_I && !MEDIA_FAIL_I) begin
          head_trk_d = tgt_trk;                                       // RQ6
          req_d      = 1'b1;
          op_d       = wrc_q ? MOP_WRITE : MOP_VERIFY;
          state_d    = S_MEDIA;
        end
      end
      S_MEDIA: begin
        if (MEDIA_DONE_I && !MEDIA_FAIL_I) begin
          remain_d = remain_q - 17'h1;
          if (remain_q == 17'h1) begin
            bsy_d   = 1'b0;                                           // RQ7
            evt_cmd = 1'b1;                                           // RQ14
            cur_d[TF_SCOUNT]  = RST_BYTE;                             // RQ10
            prev_d[TF_SCOUNT] = RST_BYTE;
            state_d = S_IDLE;
          end else begin
            addr_d = next_addr;
            adv    = 1'b1;
            if (wrc_q) begin
              bsy_d   = 1'b0;                                         // RQ4
              drq_d   = 1'b1;
              evt_cmd = 1'b1;
              widx_d  = 8'h0;
              state_d = S_XFER;
            end else begin
              state_d = S_CHECK;                                      // RQ14
            end
          end
        end
      end
    endcase
    // media error: end the command, address stays at the failing sector
    if ((state_q == S_SEEK || state_q == S_MEDIA) && MEDIA_DONE_I && MEDIA_FAIL_I) begin
      bsy_d   = 1'b0;                                                 // RQ8
      drq_d   = 1'b0;
      err_d   = 1'b1;
      ecode_d = MEDIA_ERRCODE_I;
      evt_cmd = 1'b1;                                                 // RQ14
      evt_err = 1'b1;
      state_d = S_IDLE;                                               // RQ9
    end
    // mirror the sector in hand and the count left into the task file
    if (adv) begin
      cur_d[TF_SCOUNT]  = remain_d[7:0];
      prev_d[TF_SCOUNT] = remain_d[15:8];
      if (ext_q) begin
        cur_d[TF_SNUM]    = next_addr[7:0];                           // RQ9 RQ18
        cur_d[TF_CYL_LO]  = next_addr[15:8];
        cur_d[TF_CYL_HI]  = next_addr[23:16];
        prev_d[TF_SNUM]   = next_addr[31:24];
        prev_d[TF_CYL_LO] = next_addr[39:32];
        prev_d[TF_CYL_HI] = next_addr[47:40];
      end else if (chs_q) begin
        cur_d[TF_SNUM]   = next_addr[7:0];                            // RQ9
        cur_d[TF_CYL_LO] = next_addr[23:16];
        cur_d[TF_CYL_HI] = next_addr[31:24];
        dh_d[3:0]        = next_addr[11:8];
      end else begin
        cur_d[TF_SNUM]   = next_addr[7:0];                            // RQ9
        cur_d[TF_CYL_LO] = next_addr[15:8];
        cur_d[TF_CYL_HI] = next_addr[23:16];
        dh_d[3:0]        = next_addr[27:24];
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q    <= S_IDLE;
      for (int i = 0; i < TF_NUM; i++) begin
        cur_q[i]  <= RST_BYTE;
        prev_q[i] <= RST_BYTE;
      end
      cur_q[TF_SCOUNT] <= RST_SCOUNT;
      cur_q[TF_SNUM]   <= RST_SNUM;
      dh_q       <= RST_BYTE;
      hob_q      <= 1'b0;
      bsy_q      <= 1'b0;
      drq_q      <= 1'b0;
      err_q      <= 1'b0;
      ecode_q    <= RST_BYTE;
      addr_q     <= 48'h0;
      remain_q   <= 17'h0;
      wrc_q      <= 1'b0;
      ext_q      <= 1'b0;
      chs_q      <= 1'b0;
      widx_q     <= 8'h0;
      head_trk_q <= 36'h0;
      req_q      <= 1'b0;
      op_q       <= MOP_SEEK;
    end else begin
      state_q    <= state_d;
      cur_q      <= cur_d;
      prev_q     <= prev_d;
      dh_q       <= dh_d;
      hob_q      <= hob_d;
      bsy_q      <= bsy_d;
      drq_q      <= drq_d;
      err_q      <= err_d;
      ecode_q    <= ecode_d;
      addr_q     <= addr_d;
      remain_q   <= remain_d;
      wrc_q      <= wrc_d;
      ext_q      <= ext_d;
      chs_q      <= chs_d;
      widx_q     <= widx_d;
      head_trk_q <= head_trk_d;
      req_q      <= req_d;
      op_q       <= op_d;
    end
  end

  // sector buffer: host fills it, media side reads by index
  always_ff @(posedge CLK_I) begin
    if (buf_we) begin
      buf_q[widx_q] <= WDATA_I;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      mwdata_q <= 16'h0;
    end else begin
      mwdata_q <= buf_q[MEDIA_WIDX_I];
    end
  end

  // interrupt status (write one to clear, set wins), mask, read data
  always_comb begin
    istat_d = istat_q;
    imask_d = imask_q;
    if (WR_I && (ADDR_I == OFS_INT_STAT)) begin
      istat_d = istat_q & ~WDATA_I[1:0];
    end
    if (WR_I && (ADDR_I == OFS_INT_MASK)) begin
      imask_d = WDATA_I[1:0];
    end
    istat_d[INT_CMD] = istat_d[INT_CMD] | evt_cmd;
    istat_d[INT_ERR] = istat_d[INT_ERR] | evt_err;
    irq_d   = |(istat_d & imask_d);
    rdata_d = 16'h0;
    if (RD_I) begin
      if (tf_hit) begin
        rdata_d[7:0] = hob_q ? prev_q[tf_idx] : cur_q[tf_idx];        // RQ18
      end else begin
        unique case (ADDR_I)
          OFS_DRVHEAD: rdata_d[7:0] = dh_q;
          OFS_CMD_STAT: begin
            rdata_d[ST_BSY]  = bsy_q;
            rdata_d[ST_DRDY] = 1'b1;
            rdata_d[ST_DSC]  = 1'b1;
            rdata_d[ST_DRQ]  = drq_q;                                 // RQ13
            rdata_d[ST_ERR]  = err_q;                                 // RQ8
          end
          OFS_DEVCTL:   rdata_d[DEVCTL_HOB] = hob_q;
          OFS_ERROR:    rdata_d[7:0] = ecode_q;
          OFS_INT_STAT: rdata_d[1:0] = istat_q;
          OFS_INT_MASK: rdata_d[1:0] = imask_q;
          default:      rdata_d = 16'h0;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      istat_q <= 2'h0;
      imask_q <= RST_MASK;
      irq_q   <= 1'b0;
      rdata_q <= 16'h0;
    end else begin
      istat_q <= istat_d;
      imask_q <= imask_d;
      irq_q   <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  // outputs straight from flip-flops
  assign RDATA_O       = rdata_q;
  assign IRQ_O         = irq_q;
  assign MEDIA_REQ_O   = req_q;
  assign MEDIA_OP_O    = op_q;
  assign MEDIA_ADDR_O  = addr_q;
  assign MEDIA_CHS_O   = chs_q;
  assign MEDIA_WDATA_O = mwdata_q;

endmodule

// file: common/ata_wv_pkg.sv
// Notes on behaviour
// (RQ1) Codes 30h and 31h write the sector count (1 to 256) from the start sector.
// (RQ2) A write command raises DRQ at once; host data fills the sector buffer.
// (RQ3) A full sector in the buffer drops DRQ, raises BSY, starts the media write.
// (RQ4) Between sectors of a write: DRQ up, BSY down, interrupt for the next sector.
// (RQ5) Host moves exactly one sector per DRQ phase of a write.
// (RQ6) Head off the target track: seek first, then write or verify.
// (RQ7) Last sector written: BSY down and a completion interrupt.
// (RQ8) Error mid-write ends the command, posts status and error, no more DRQ.
// (RQ9) After an error the address registers hold the failing sector address.
// (RQ10) Normal completion of a write leaves the sector count reading 00h.
// (RQ11) Code 34h is the extended write, 1 to 65536 sectors, same handshake.
// (RQ12) Extended write and extended verify run in block addressing only.
// (RQ13) Code 40h verifies sectors on the media; DRQ never rises, no data out.
// (RQ14) A verify raises exactly one interrupt, at completion or on error.
// (RQ15) Code 42h is the extended verify, no data to the host.
// (RQ16) Code 3Ch behaves as write sector, 1 to 256, with no read-back.
// (RQ17) Host loads select, address and count before writing the command.
// (RQ18) Extended address and count bytes keep current and previous; HOB selects.
package ata_wv_pkg;

  // register offsets on the register port
  localparam logic [3:0] OFS_DATA     = 4'h0;
  localparam logic [3:0] OFS_FEATURES = 4'h1;
  localparam logic [3:0] OFS_SCOUNT   = 4'h2;
  localparam logic [3:0] OFS_SNUM     = 4'h3;
  localparam logic [3:0] OFS_CYL_LO   = 4'h4;
  localparam logic [3:0] OFS_CYL_HI   = 4'h5;
  localparam logic [3:0] OFS_DRVHEAD  = 4'h6;
  localparam logic [3:0] OFS_CMD_STAT = 4'h7;
  localparam logic [3:0] OFS_DEVCTL   = 4'h8;
  localparam logic [3:0] OFS_ERROR    = 4'h9;
  localparam logic [3:0] OFS_INT_STAT = 4'ha;
  localparam logic [3:0] OFS_INT_MASK = 4'hb;

  // index of a two-byte task-file register (offset minus one)
  localparam logic [2:0] TF_SCOUNT = 3'h1;
  localparam logic [2:0] TF_SNUM   = 3'h2;
  localparam logic [2:0] TF_CYL_LO = 3'h3;
  localparam logic [2:0] TF_CYL_HI = 3'h4;
  localparam int         TF_NUM    = 5;

  // command codes
  localparam logic [7:0] CMD_WRITE     = 8'h30;
  localparam logic [7:0] CMD_WRITE_NR  = 8'h31;
  localparam logic [7:0] CMD_WRITE_EXT = 8'h34;
  localparam logic [7:0] CMD_WRITE_VFY = 8'h3c;
  localparam logic [7:0] CMD_VERIFY    = 8'h40;
  localparam logic [7:0] CMD_VERIFY_EXT = 8'h42;

  // field positions
  localparam int ST_BSY     = 7;
  localparam int ST_DRDY    = 6;
  localparam int ST_DSC     = 4;
  localparam int ST_DRQ     = 3;
  localparam int ST_ERR     = 0;
  localparam int ERR_ABRT   = 2;
  localparam int DEVCTL_HOB = 7;
  localparam int DH_LBA     = 6;
  localparam int INT_CMD    = 0;
  localparam int INT_ERR    = 1;
  localparam int TRACK_LSB  = 12;

  // sector shape and addressing geometry
  localparam int         SECTOR_WORDS = 256;
  localparam logic [7:0] LAST_WORD    = 8'hff;
  localparam logic [3:0] LAST_HEAD    = 4'hf;
  localparam logic [7:0] SECT_PER_TRK = 8'h3f;

  // reset values
  localparam logic [7:0] RST_SCOUNT = 8'h01;
  localparam logic [7:0] RST_SNUM   = 8'h01;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [1:0] RST_MASK   = 2'h3;

  typedef enum logic [1:0] {
    MOP_SEEK,
    MOP_WRITE,
    MOP_VERIFY
  } media_op_t;

endpackage

// file: tb/ata_wv_seq_chk.sv
`timescale 1ns/100ps
module ata_wv_seq_chk
  import ata_wv_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic [3:0]  ADDR_I,
  input  wire logic [15:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  input  wire logic [15:0] RDATA_O,
  input  wire logic        IRQ_O,
  input  wire logic        MEDIA_REQ_O,
  input  wire logic [1:0]  MEDIA_OP_O,
  input  wire logic [47:0] MEDIA_ADDR_O,
  input  wire logic        MEDIA_DONE_I,
  input  wire logic        MEDIA_FAIL_I
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  // read slot and status relations
  property p_rdata_idle;
    !RD_I |=> RDATA_O == 16'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its slot");
  property p_drq_at_cmd;
    WR_I && ADDR_I == OFS_CMD_STAT && WDATA_I[7:0] == CMD_WRITE ##1 RD_I && ADDR_I == OFS_CMD_STAT
      |=> RDATA_O[ST_DRQ];
  endproperty
  a_drq_at_cmd: assert property (p_drq_at_cmd) else $error("no data request after write command");
  property p_busy_media;
    RD_I && ADDR_I == OFS_CMD_STAT && MEDIA_REQ_O |=> RDATA_O[ST_BSY] && !RDATA_O[ST_DRQ];
  endproperty
  a_busy_media: assert property (p_busy_media) else $error("status not busy during media work");
  property p_no_both;
    RD_I && ADDR_I == OFS_CMD_STAT |=> !(RDATA_O[ST_BSY] && RDATA_O[ST_DRQ]);
  endproperty
  a_no_both: assert property (p_no_both) else $error("busy and data request together");

  // media request handshake
  property p_req_hold;
    MEDIA_REQ_O && !MEDIA_DONE_I |=> MEDIA_REQ_O && $stable(MEDIA_OP_O) && $stable(MEDIA_ADDR_O);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("media request changed before done");
  property p_req_drop;
    MEDIA_REQ_O && MEDIA_DONE_I && (MEDIA_OP_O != MOP_SEEK || MEDIA_FAIL_I) |=> !MEDIA_REQ_O;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("media request kept after done");
  property p_seek_next;
    MEDIA_REQ_O && MEDIA_DONE_I && !MEDIA_FAIL_I && MEDIA_OP_O == MOP_SEEK |=> MEDIA_REQ_O && MEDIA_OP_O != MOP_SEEK;
  endproperty
  a_seek_next: assert property (p_seek_next) else $error("no transfer after seek");

  // interrupt masking and clearing
  property p_mask_irq;
    WR_I && ADDR_I == OFS_INT_MASK && WDATA_I[1:0] == 2'h0 |=> ##1 !IRQ_O;
  endproperty
  a_mask_irq: assert property (p_mask_irq) else $error("interrupt high with mask clear");
  property p_clear_irq;
    WR_I && ADDR_I == OFS_INT_STAT && WDATA_I[1:0] == 2'h3 && !MEDIA_DONE_I |=> ##1 !IRQ_O;
  endproperty
  a_clear_irq: assert property (p_clear_irq) else $error("interrupt high after clear");
endmodule

// file: tb/ata_media_model.sv
`timescale 1ns/100ps
module ata_media_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       req_i,
  input  wire logic [3:0] dly_i,
  input  wire logic       fail_sel_i,
  input  wire logic [7:0] errcode_i,
  output logic            done_o,
  output logic            fail_o,
  output logic [7:0]      errcode_o,
  output logic [7:0]      widx_o
);
  logic [4:0] cnt_q;
  logic       fire;

  // answer a request dly_i + 1 cycles after it rises, never in the cycle it rises
  assign fire = req_i && !done_o && cnt_q >= {1'b0, dly_i};

  // qualifiers toggle off the pulse so stale values never pass
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 5'h0;
      done_o <= 1'b0;
      fail_o <= 1'b0;
      errcode_o <= 8'h0;
      widx_o <= 8'h0;
    end else begin
      cnt_q <= (req_i && !done_o && !fire) ? cnt_q + 5'h1 : 5'h0;
      done_o <= fire;
      fail_o <= fire ? fail_sel_i : ~fail_o;
      errcode_o <= fire ? errcode_i : ~errcode_o;
      widx_o <= req_i ? widx_o + 8'h1 : 8'h0;
    end
  end
endmodule

// file: tb/ata_write_verify_sequencer_tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, s) begin checks_done++; if ((e) !== (s)) begin n_errors++; \
  $display("wrong value %s exp %h seen %h", nm, e, s); end end
module ata_write_verify_sequencer_tb;
  import ata_wv_pkg::*;
  typedef struct packed {logic [15:0] v; logic [15:0] m; logic [1:0] q; logic [3:0] a;} exp_t;
  localparam logic [7:0] ERRCODE = 8'h40;
  logic        CLK_I, RST_N_I, WR_I, RD_I, IRQ_O, MEDIA_REQ_O, MEDIA_DONE_I, MEDIA_FAIL_I;
  logic [3:0]  ADDR_I;
  logic [15:0] WDATA_I, RDATA_O, MEDIA_WDATA_O;
  logic [1:0]  MEDIA_OP_O;
  logic [47:0] MEDIA_ADDR_O, addr_x;
  logic        MEDIA_CHS_O, chs_x;
  logic        first_op = 1'b0;
  logic [7:0]  widx_p;
  logic [15:0] words [SECTOR_WORDS];
  logic [7:0]  MEDIA_ERRCODE_I, MEDIA_WIDX_I;
  logic [3:0]  dly;
  logic        fail_sel, vfy;
  logic        rd_q = 1'b0;
  logic [7:0]  cmds [6] = '{CMD_WRITE, CMD_WRITE_NR, CMD_WRITE_VFY, CMD_WRITE_EXT, CMD_VERIFY, CMD_VERIFY_EXT};
  int          seed, n_errors, checks_done;
  exp_t        notes [$];
  exp_t        e;

  ata_write_verify_sequencer uut (.CLK_I, .RST_N_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .IRQ_O,
    .MEDIA_REQ_O, .MEDIA_OP_O, .MEDIA_ADDR_O, .MEDIA_CHS_O, .MEDIA_DONE_I, .MEDIA_FAIL_I,
    .MEDIA_ERRCODE_I, .MEDIA_WIDX_I, .MEDIA_WDATA_O);
  ata_media_model media (.clk_i(CLK_I), .rst_n_i(RST_N_I), .req_i(MEDIA_REQ_O), .dly_i(dly),
    .fail_sel_i(fail_sel), .errcode_i(ERRCODE), .done_o(MEDIA_DONE_I), .fail_o(MEDIA_FAIL_I),
    .errcode_o(MEDIA_ERRCODE_I), .widx_o(MEDIA_WIDX_I));

  // clock
  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end

  // pairs each read slot with the oldest note
  always @(posedge CLK_I) begin
    if (rd_q) begin
      e = notes.pop_front();
      `CHK($sformatf("offset %h", e.a), e.v & e.m, RDATA_O & e.m)
      if (e.q[1]) `CHK("irq", e.q[0], IRQ_O)
    end
    rd_q <= RD_I;
  end

  // media side: first address, address form, words leaving the buffer
  always @(posedge CLK_I) begin
    if (MEDIA_REQ_O && MEDIA_DONE_I) begin
      `CHK("media form", chs_x, MEDIA_CHS_O)
      if (first_op) `CHK("media address", addr_x, MEDIA_ADDR_O)
    end
    if (MEDIA_REQ_O && MEDIA_OP_O == MOP_WRITE) `CHK("media word", words[widx_p], MEDIA_WDATA_O)
    first_op <= (WR_I && ADDR_I == OFS_CMD_STAT) || (first_op && !(MEDIA_REQ_O && MEDIA_DONE_I));
    widx_p   <= MEDIA_WIDX_I;
  end

  function automatic logic [15:0] st(input logic b, input logic d, input logic r);
    st = 16'h50;
    st[ST_BSY] = b;
    st[ST_DRQ] = d;
    st[ST_ERR] = r;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    RD_I <= 1'b0;
    @(posedge CLK_I);
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] v, input logic [15:0] m = 16'hffff,
                    input logic [1:0] q = 2'b00);
    notes.push_back('{v, m, q, a});
    ADDR_I <= a;
    WR_I <= 1'b0;
    RD_I <= 1'b1;
    @(posedge CLK_I);
  endtask

  task automatic quiet(input int n);
    WR_I <= 1'b0;
    RD_I <= 1'b0;
    repeat (n) @(posedge CLK_I);
  endtask

  task automatic wait_irq;
    int i;
    quiet(1);
    for (i = 0; i < 3000 && IRQ_O !== 1'b1; i++) @(negedge CLK_I);
    if (IRQ_O !== 1'b1) n_errors++;
    @(posedge CLK_I);
  endtask

  // one sector of random words, exactly one per data request phase
  task automatic sector;
    for (int w = 0; w < SECTOR_WORDS; w++) begin
      words[w] = 16'($random(seed));
      wr(OFS_DATA, words[w]);
    end
  endtask

  // both bytes of every register but features loaded before the command
  task automatic issue(input logic [7:0] cmd, input logic [7:0] dh, input logic [7:0] cnt,
                       input logic [7:0] sn, input logic [7:0] cl);
    logic [3:0] ofs [5];
    logic [7:0] val [5];
    ofs = '{OFS_DRVHEAD, OFS_SCOUNT, OFS_SNUM, OFS_CYL_LO, OFS_CYL_HI};
    val = '{dh, cnt, sn, cl, 8'h0};
    chs_x = !dh[DH_LBA];
    addr_x = dh[DH_LBA] ? {20'h0, dh[3:0], 8'h0, cl, sn} : {24'h0, cl, 4'h0, dh[3:0], sn};
    for (int k = 0; k < 5; k++) begin
      wr(ofs[k], 16'h0);
      wr(ofs[k], {8'h0, val[k]});
    end
    wr(OFS_CMD_STAT, {8'h0, cmd});
  endtask

  task automatic finish_test;
    if (n_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #(20000 * 10);
    n_errors++;
    finish_test();
  end

  // main sequence
  initial begin
    seed = 32'hc76515fd;
    {ADDR_I, WDATA_I, WR_I, RD_I, fail_sel, dly} = '0;
    RST_N_I = 1'b0;
    repeat (8) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    @(posedge CLK_I);
    rd(OFS_CMD_STAT, st(0, 0, 0));
    rd(OFS_SCOUNT, 16'h1);
    rd(OFS_INT_MASK, 16'h3, 16'h3);
    rd(4'hc, 16'h0);
    // two-sector write in cylinder form, same track
    issue(CMD_WRITE, 8'h00, 8'h2, 8'h1, 8'h0);
    rd(OFS_CMD_STAT, st(0, 1, 0));
    sector();
    rd(OFS_CMD_STAT, st(1, 0, 0));
    wait_irq();
    rd(OFS_CMD_STAT, st(0, 1, 0), 16'hffff, 2'b11);
    wr(OFS_INT_STAT, 16'h3);
    sector();
    wait_irq();
    rd(OFS_CMD_STAT, st(0, 0, 0), 16'hffff, 2'b11);
    rd(OFS_SCOUNT, 16'h0);
    wr(OFS_INT_STAT, 16'h3);
    // every command in block form, new track each time
    foreach (cmds[k]) begin
      dly <= 4'($random(seed));
      issue(cmds[k], 8'h40, 8'h1, 8'h0, {4'(k + 1), 4'h0});
      vfy = cmds[k][6];
      repeat (2) rd(OFS_CMD_STAT, st(vfy, !vfy, 0));
      if (!vfy) sector();
      wait_irq();
      rd(OFS_INT_STAT, 16'h1, 16'h3);
      rd(OFS_CMD_STAT, st(0, 0, 0));
      rd(OFS_SCOUNT, 16'h0);
      wr(OFS_INT_STAT, 16'h3);
    end
    // previous byte through the high-order select
    wr(OFS_SCOUNT, 16'ha5);
    wr(OFS_SCOUNT, 16'h5a);
    wr(OFS_DEVCTL, 16'h80);
    rd(OFS_SCOUNT, 16'ha5, 16'hff);
    wr(OFS_DEVCTL, 16'h0);
    rd(OFS_SCOUNT, 16'h5a, 16'hff);
    // extended write without block addressing is aborted
    issue(CMD_WRITE_EXT, 8'h00, 8'h1, 8'h1, 8'h0);
    wait_irq();
    rd(OFS_CMD_STAT, st(0, 0, 1));
    rd(OFS_ERROR, 16'h4, 16'h4);
    wr(OFS_INT_STAT, 16'h3);
    // media failure on the second of three sectors
    issue(CMD_WRITE, 8'h00, 8'h3, 8'h1, 8'h0);
    sector();
    wait_irq();
    wr(OFS_INT_STAT, 16'h3);
    fail_sel <= 1'b1;
    sector();
    wait_irq();
    fail_sel <= 1'b0;
    rd(OFS_CMD_STAT, st(0, 0, 1));
    rd(OFS_ERROR, {8'h0, ERRCODE});
    rd(OFS_SCOUNT, 16'h2);
    rd(OFS_SNUM, 16'h2);
    rd(OFS_INT_STAT, 16'h3, 16'h3);
    wr(OFS_INT_MASK, 16'h0);
    quiet(2);
    rd(OFS_CMD_STAT, st(0, 0, 1), 16'hffff, 2'b10);
    wr(OFS_INT_MASK, 16'h3);
    quiet(2);
    rd(OFS_CMD_STAT, st(0, 0, 1), 16'hffff, 2'b11);
    wr(OFS_INT_STAT, 16'h3);
    quiet(2);
    rd(OFS_INT_STAT, 16'h0, 16'h3, 2'b10);
    quiet(4);
    finish_test();
  end
endmodule

bind ata_write_verify_sequencer ata_wv_seq_chk chk (.CLK_I, .RST_N_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
  .RDATA_O, .IRQ_O, .MEDIA_REQ_O, .MEDIA_OP_O, .MEDIA_ADDR_O, .MEDIA_DONE_I, .MEDIA_FAIL_I);
